/* File: mcu_pkg.sv */
// maintenance command unit: shared constants and types
package mcu_pkg;

  localparam int NCMD = 10;

  // command slots, in register order
  localparam logic [3:0] I_ALARM_RESET = 4'h0;
  localparam logic [3:0] I_ALARM_CLR = 4'h1;
  localparam logic [3:0] I_WARN_CLR = 4'h2;
  localparam logic [3:0] I_COMM_CLR = 4'h3;
  localparam logic [3:0] I_POS_PRESET = 4'h4;
  localparam logic [3:0] I_RECALC = 4'h5;
  localparam logic [3:0] I_DEFAULTS = 4'h6;
  localparam logic [3:0] I_NV_LOAD = 4'h7;
  localparam logic [3:0] I_NV_STORE = 4'h8;
  localparam logic [3:0] I_ENC_LOAD = 4'h9;

  // register addresses of the upper halves (even); lower half is +1
  localparam logic [15:0] ALARM_RESET_CMD = 16'h0180;
  localparam logic [15:0] ALARM_HISTORY_CLEAR_CMD = 16'h0184;
  localparam logic [15:0] WARNING_HISTORY_CLEAR_CMD = 16'h0186;
  localparam logic [15:0] COMM_ERROR_HISTORY_CLEAR_CMD = 16'h0188;
  localparam logic [15:0] POSITION_PRESET_CMD = 16'h018a;
  localparam logic [15:0] RECALC_SETUP_CMD = 16'h018c;
  localparam logic [15:0] FACTORY_DEFAULTS_CMD = 16'h018e;
  localparam logic [15:0] NV_LOAD_TO_RAM_CMD = 16'h0190;
  localparam logic [15:0] RAM_STORE_TO_NV_CMD = 16'h0192;
  localparam logic [15:0] ENCODER_LOAD_CMD = 16'h0194;

  localparam logic [NCMD-1:0][15:0] CMD_ADDR = {
    ENCODER_LOAD_CMD, RAM_STORE_TO_NV_CMD, NV_LOAD_TO_RAM_CMD,
    FACTORY_DEFAULTS_CMD, RECALC_SETUP_CMD, POSITION_PRESET_CMD,
    COMM_ERROR_HISTORY_CLEAR_CMD, WARNING_HISTORY_CLEAR_CMD,
    ALARM_HISTORY_CLEAR_CMD, ALARM_RESET_CMD};

  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [31:0] CMD_TRIGGER = 32'h0000_0001;
  localparam logic [31:0] CMD_MAX_RANGED = 32'h0000_0001;

  typedef enum logic [1:0] {
    MCU_CFG_IDLE = 2'b01,
    MCU_CFG_RUN = 2'b10
  } mcu_cfg_t;

  // one 16-bit register write delivered by the serial front end
  typedef struct packed {
    logic en;
    logic [15:0] addr;
    logic [15:0] data;
  } mcu_wr_t;

  typedef struct packed {
    logic hit;
    logic lower;
    logic [3:0] idx;
  } mcu_dec_t;

  typedef struct packed {
    logic [NCMD-1:0][31:0] val;
    logic [NCMD-1:0] fire;
    mcu_cfg_t cfg;
    logic rejected;
    logic refused;
    logic zero_pos;
    logic alarm_ind;
  } mcu_state_t;

endpackage

/* File: mcu_maintenance_command_unit.sv */
// maintenance command unit: command registers, triggers, setup sequence
// Operation
// - every command register is writable; action fires only on 0 to 1
// - 32-bit value: even register upper half, odd register lower half
// - alarm reset trigger clears active alarms except non-resettable ones
// - alarm history clear trigger erases all alarm records
// - warning history clear trigger erases all warning records
// - comm error history clear trigger erases all comm error records
// - position preset loads command and feedback position; values 0 or 1
// - setup trigger recomputes derived parameters and runs setup; 0 or 1
// - full initialization restores stored data and parameters to defaults
// - nv load copies stored parameters into RAM, overwriting everything
// - nv store copies RAM parameters into non-volatile storage
// - encoder load sets encoder counter from encoder preset parameter
// - setup runs only with no alarm and motor stopped, else refused
// - setup refused while setting tool or PC software is busy
// - during setup: no excitation, brake holds, alarm lamp off, I/O off
// - setup end zeroes command and feedback position, re-enables outputs
// - setup leaves the encoder counter untouched
`timescale 1ns/1ps
`default_nettype none

module mcu_maintenance_command_unit (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire mcu_pkg::mcu_wr_t wr,
  input wire logic alarm_active,
  input wire logic motor_running,
  input wire logic tool_busy,
  input wire logic pc_busy,
  input wire logic recalc_done,
  output logic [mcu_pkg::NCMD-1:0] cmd_fire,
  output logic reg_rejected,
  output logic cfg_refused,
  output logic configuring,
  output logic zero_positions,
  output logic excitation_off,
  output logic brake_hold,
  output logic alarm_indicator,
  output logic inputs_blocked,
  output logic outputs_valid
);

  // -------------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------------

  function automatic mcu_pkg::mcu_dec_t mcu_decode(input logic [15:0] a);
    mcu_pkg::mcu_dec_t d;
    d = '0;
    for (int k = 0; k < mcu_pkg::NCMD; k++)
    begin
      if (a[15:1] == mcu_pkg::CMD_ADDR[k][15:1])
      begin
        d.hit = 1'b1;
        d.idx = 4'(k);
      end
    end
    d.lower = a[0];
    return d;
  endfunction

  // preset and setup only accept the values 0 and 1
  function automatic logic mcu_ranged(input logic [3:0] i);
    return (i == mcu_pkg::I_POS_PRESET) || (i == mcu_pkg::I_RECALC);
  endfunction

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------

  mcu_pkg::mcu_state_t st;
  mcu_pkg::mcu_state_t next_st;
  mcu_pkg::mcu_dec_t dec;
  logic [31:0] old_val;
  logic [31:0] new_val;
  logic cfg_ok;

  always_comb
  begin
    next_st = st;
    next_st.fire = '0;
    next_st.rejected = 1'b0;
    next_st.refused = 1'b0;
    next_st.zero_pos = 1'b0;
    dec = mcu_decode(wr.addr);
    old_val = dec.hit ? st.val[dec.idx] : mcu_pkg::CMD_RESET;
    new_val = old_val;
    // a busy tool or PC, a live alarm or a moving motor blocks setup
    cfg_ok = !alarm_active && !motor_running && !tool_busy && !pc_busy &&
             (st.cfg == mcu_pkg::MCU_CFG_IDLE);
    if (wr.en && dec.hit)
    begin
      if (dec.lower)
      begin
        new_val[15:0] = wr.data;
      end
      else
      begin
        new_val[31:16] = wr.data;
      end
      if (mcu_ranged(dec.idx) && new_val > mcu_pkg::CMD_MAX_RANGED)
      begin
        next_st.rejected = 1'b1;
      end
      else
      begin
        next_st.val[dec.idx] = new_val;
        // only a genuine 0 to 1 step launches; anything else is just stored
        if (old_val == mcu_pkg::CMD_RESET &&
            new_val == mcu_pkg::CMD_TRIGGER)
        begin
          if (dec.idx != mcu_pkg::I_RECALC)
          begin
            // alarm reset, history clears, preset, init, nv moves, encoder
            next_st.fire[dec.idx] = 1'b1;
          end
          else if (cfg_ok)
          begin
            next_st.fire[dec.idx] = 1'b1;
            next_st.cfg = mcu_pkg::MCU_CFG_RUN;
          end
          else
          begin
            next_st.refused = 1'b1;
          end
        end
      end
    end
    // setup ends: positions zeroed, encoder counter left alone
    if (st.cfg == mcu_pkg::MCU_CFG_RUN && recalc_done)
    begin
      next_st.cfg = mcu_pkg::MCU_CFG_IDLE;
      next_st.zero_pos = 1'b1;
    end
    // lamp is forced dark for the whole setup run
    next_st.alarm_ind = alarm_active &&
                        (next_st.cfg != mcu_pkg::MCU_CFG_RUN);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.val <= '0;
      st.fire <= '0;
      st.cfg <= mcu_pkg::MCU_CFG_IDLE;
      st.rejected <= 1'b0;
      st.refused <= 1'b0;
      st.zero_pos <= 1'b0;
      st.alarm_ind <= 1'b0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------

  // fire bits: alarm reset, history clears, preset, setup start, defaults,
  // nv load, nv store and encoder load, each one enabled clock wide (held while ce is low)
  assign cmd_fire = st.fire;
  assign reg_rejected = st.rejected;
  assign cfg_refused = st.refused;
  assign configuring = (st.cfg == mcu_pkg::MCU_CFG_RUN);
  assign zero_positions = st.zero_pos;
  assign excitation_off = configuring;
  assign brake_hold = configuring;
  assign alarm_indicator = st.alarm_ind;
  assign inputs_blocked = configuring;
  // monitor data behind this flag is not trustworthy during setup
  assign outputs_valid = !configuring;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  mcu_pkg::mcu_dec_t chk_dec;
  logic cfg_write_one;
  logic preset_write_two;

  assign chk_dec = mcu_decode(wr.addr);
  assign cfg_write_one = ce && wr.en && chk_dec.hit && chk_dec.lower &&
                         chk_dec.idx == mcu_pkg::I_RECALC &&
                         wr.data == 16'h0001 &&
                         st.val[mcu_pkg::I_RECALC] == mcu_pkg::CMD_RESET;
  assign preset_write_two = ce && wr.en && chk_dec.hit && chk_dec.lower &&
                            chk_dec.idx == mcu_pkg::I_POS_PRESET &&
                            wr.data == 16'h0002;

  sequence cfg_req_s;
    cfg_write_one && !alarm_active && !motor_running && !tool_busy &&
    !pc_busy && !configuring;
  endsequence

  sequence cfg_start_s;
    cmd_fire[mcu_pkg::I_RECALC] && configuring && excitation_off;
  endsequence

  alarm_reset_rise_a: assert property (
    $rose(cmd_fire[mcu_pkg::I_ALARM_RESET]) |->
      st.val[mcu_pkg::I_ALARM_RESET] == mcu_pkg::CMD_TRIGGER &&
      $past(st.val[mcu_pkg::I_ALARM_RESET]) == mcu_pkg::CMD_RESET)
    else $error("alarm reset fired without a 0 to 1 step");

  rearm_no_fire_a: assert property (
    ce && st.val[mcu_pkg::I_ENC_LOAD] != mcu_pkg::CMD_RESET |=>
      !cmd_fire[mcu_pkg::I_ENC_LOAD])
    else $error("encoder load fired from a non-zero value");

  cfg_start_a: assert property (
    cfg_req_s |=> cfg_start_s)
    else $error("accepted setup request did not start setup");

  cfg_alarm_block_a: assert property (
    cfg_write_one && !configuring && (alarm_active || motor_running) |=>
      cfg_refused && !configuring)
    else $error("setup ran with alarm or motor running");

  cfg_tool_block_a: assert property (
    cfg_write_one && !configuring && (tool_busy || pc_busy) |=>
      cfg_refused && !configuring && !cmd_fire[mcu_pkg::I_RECALC])
    else $error("setup ran while tool or PC busy");

  cfg_run_state_a: assert property (
    configuring |-> excitation_off && brake_hold && !alarm_indicator &&
      inputs_blocked && !outputs_valid)
    else $error("wrong drive state during setup");

  cfg_done_zero_a: assert property (
    configuring && ce && recalc_done |=>
      zero_positions && !configuring && outputs_valid)
    else $error("setup end did not zero positions");

  preset_range_a: assert property (
    preset_write_two |=> reg_rejected ##0
      !cmd_fire[mcu_pkg::I_POS_PRESET] ##0
      $stable(st.val[mcu_pkg::I_POS_PRESET]))
    else $error("out of range preset value accepted");

  zero_only_end_a: assert property (
    $rose(zero_positions) |-> $past(configuring) && !configuring)
    else $error("positions zeroed outside setup end");

  // -------------------------------------------------------------------------
  // per-command, range and freeze checks
  // -------------------------------------------------------------------------

  logic setup_write_two;
  logic unmapped_write;

  assign setup_write_two = ce && wr.en && chk_dec.hit && chk_dec.lower &&
                           chk_dec.idx == mcu_pkg::I_RECALC &&
                           wr.data == 16'h0002;
  assign unmapped_write = ce && wr.en && !chk_dec.hit;

  sequence frozen_s;
    !ce;
  endsequence

  // every registered output keeps its value across a frozen cycle
  sequence held_s;
    $stable(cmd_fire) && $stable(configuring) && $stable(reg_rejected) &&
    $stable(cfg_refused) && $stable(zero_positions) &&
    $stable(alarm_indicator);
  endsequence

  sequence setup_rejected_s;
    reg_rejected && !configuring && !cmd_fire[mcu_pkg::I_RECALC];
  endsequence

  ce_freeze_a: assert property (
    frozen_s |=> held_s)
    else $error("state moved while clock enable was low");

  // a pulse stretched by a freeze is checked only on its rising edge
  genvar g;
  generate
    for (g = 0; g < mcu_pkg::NCMD; g++)
    begin : g_fire_chk
      fire_step_a: assert property (
        $rose(cmd_fire[g]) |-> st.val[g] == mcu_pkg::CMD_TRIGGER &&
          $past(st.val[g]) == mcu_pkg::CMD_RESET)
        else $error("command fired without a 0 to 1 step");

      fire_width_a: assert property (
        ce && cmd_fire[g] |=> !cmd_fire[g])
        else $error("command fire held longer than one cycle");
    end
  endgenerate

  fire_single_a: assert property (
    $onehot0(cmd_fire))
    else $error("more than one command fired at once");

  unmapped_quiet_a: assert property (
    unmapped_write |=> !(|cmd_fire) && !reg_rejected)
    else $error("write to an unmapped register had an effect");

  setup_range_a: assert property (
    setup_write_two |=> setup_rejected_s ##0
      $stable(st.val[mcu_pkg::I_RECALC]))
    else $error("out of range setup value accepted");

  reject_no_fire_a: assert property (
    reg_rejected |-> !(|cmd_fire))
    else $error("rejected write launched a command");

  refuse_no_run_a: assert property (
    cfg_refused |-> !cmd_fire[mcu_pkg::I_RECALC])
    else $error("refused setup still launched");

  busy_no_start_a: assert property (
    ce && (tool_busy || pc_busy) |=> !$rose(configuring))
    else $error("setup started while tool or PC busy");

  alarm_no_start_a: assert property (
    ce && (alarm_active || motor_running) |=> !$rose(configuring))
    else $error("setup started with alarm or motor running");

  lamp_follow_a: assert property (
    ce && !configuring |=>
      configuring || alarm_indicator == $past(alarm_active))
    else $error("alarm lamp does not follow the alarm outside setup");

  idle_no_zero_a: assert property (
    ce && !configuring |=> !zero_positions)
    else $error("positions zeroed while no setup ran");

endmodule

`default_nettype wire

/* File: mcu_host_model.sv */
// host model: sends each 32-bit command as two 16-bit register writes
`timescale 1ns/1ps
`default_nettype none

module mcu_host_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req,
  input wire logic [15:0] base,
  input wire logic [31:0] value,
  output var mcu_pkg::mcu_wr_t wr
);
  logic [1:0] ph;
  logic [31:0] v;
  logic [15:0] a;

  // idle bus toggles so a stale address or value can never look valid
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ph <= 2'h0;
      v <= 32'h0000_0000;
      a <= 16'h0000;
      wr <= '0;
    end
    else if (req && ph == 2'h0)
    begin
      ph <= 2'h1;
      v <= value;
      a <= base;
      wr <= {1'b1, base, value[31:16]};
    end
    else if (ph == 2'h1)
    begin
      ph <= 2'h2;
      wr <= {1'b1, a | 16'h0001, v[15:0]};
    end
    else
    begin
      ph <= 2'h0;
      wr <= {1'b0, ~wr.addr, ~wr.data};
    end
  end
endmodule
`default_nettype wire

/* File: mcu_maintenance_command_unit_tb.sv */
// self-checking bench for the maintenance command unit
`timescale 1ns/1ps
`default_nettype none

module mcu_maintenance_command_unit_tb;
  logic mclk, reset_n, req, alarm_active, motor_running;
  logic tool_busy, pc_busy, recalc_done;
  logic [15:0] base;
  logic [31:0] value;
  mcu_pkg::mcu_wr_t wr;
  logic [mcu_pkg::NCMD-1:0] cmd_fire;
  logic reg_rejected, cfg_refused, configuring, zero_positions;
  logic excitation_off, brake_hold, alarm_indicator;
  logic inputs_blocked, outputs_valid;
  logic ce;
  int error_cnt, cmp_count;

  mcu_host_model u_mcu_host_model (.mclk(mclk), .reset_n(reset_n),
    .req(req), .base(base), .value(value), .wr(wr));
  mcu_maintenance_command_unit u_mcu_maintenance_command_unit (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .wr(wr),
    .alarm_active(alarm_active), .motor_running(motor_running),
    .tool_busy(tool_busy), .pc_busy(pc_busy), .recalc_done(recalc_done),
    .cmd_fire(cmd_fire), .reg_rejected(reg_rejected),
    .cfg_refused(cfg_refused), .configuring(configuring),
    .zero_positions(zero_positions), .excitation_off(excitation_off),
    .brake_hold(brake_hold), .alarm_indicator(alarm_indicator),
    .inputs_blocked(inputs_blocked), .outputs_valid(outputs_valid));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task summarize();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // returns just after the edge that takes the lower half
  task wr32(input logic [15:0] b, input logic [31:0] v);
    @(posedge mclk);
    req <= 1'b1;
    base <= b;
    value <= v;
    @(posedge mclk);
    req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_each();
    for (int i = 0; i < mcu_pkg::NCMD; i++)
    begin
      if (i == 5)
        continue;
      wr32(mcu_pkg::CMD_ADDR[i], mcu_pkg::CMD_TRIGGER);
      chk(cmd_fire === (10'h001 << i), "no fire on 0 to 1");
      wr32(mcu_pkg::CMD_ADDR[i], mcu_pkg::CMD_TRIGGER);
      chk(cmd_fire === 10'h000, "fire on 1 to 1");
      wr32(mcu_pkg::CMD_ADDR[i], mcu_pkg::CMD_RESET);
      chk(cmd_fire === 10'h000, "fire on write 0");
    end
  endtask

  task t_reject();
    wr32(mcu_pkg::POSITION_PRESET_CMD, 32'h0000_0002);
    chk(reg_rejected === 1'b1 && cmd_fire === 10'h000, "no reject");
    wr32(mcu_pkg::POSITION_PRESET_CMD, mcu_pkg::CMD_TRIGGER);
    chk(cmd_fire === 10'h010, "rejected value stored");
    wr32(mcu_pkg::POSITION_PRESET_CMD, mcu_pkg::CMD_RESET);
    wr32(16'h0182, mcu_pkg::CMD_TRIGGER);
    chk(cmd_fire === 10'h000, "unmapped fired");
    wr32(mcu_pkg::RECALC_SETUP_CMD, 32'h0000_0002);
    chk(reg_rejected === 1'b1 && configuring === 1'b0, "no reject");
    wr32(mcu_pkg::ALARM_HISTORY_CLEAR_CMD, 32'h0001_0001);
    chk(cmd_fire === 10'h000, "upper half ignored");
    wr32(mcu_pkg::ALARM_HISTORY_CLEAR_CMD, mcu_pkg::CMD_RESET);
    chk(cmd_fire === 10'h000, "fire on 1 to 0 via halves");
  endtask

  task t_freeze();
    ce <= 1'b0;
    wr32(mcu_pkg::ALARM_RESET_CMD, mcu_pkg::CMD_TRIGGER);
    chk(cmd_fire === 10'h000, "write taken while frozen");
    ce <= 1'b1;
    wr32(mcu_pkg::ALARM_RESET_CMD, mcu_pkg::CMD_TRIGGER);
    chk(cmd_fire === 10'h001, "no fire after freeze");
    ce <= 1'b0;
    @(posedge mclk);
    #1;
    chk(cmd_fire === 10'h001, "pulse not held while frozen");
    ce <= 1'b1;
    wr32(mcu_pkg::ALARM_RESET_CMD, mcu_pkg::CMD_RESET);
    chk(cmd_fire === 10'h000, "fire on write 0");
  endtask

  task t_refuse();
    for (int k = 0; k < 4; k++)
    begin
      {alarm_active, motor_running, tool_busy, pc_busy} <= 4'h8 >> k;
      wr32(mcu_pkg::RECALC_SETUP_CMD, mcu_pkg::CMD_TRIGGER);
      chk(cfg_refused === 1'b1, "setup not refused");
      chk(configuring === 1'b0 && cmd_fire === 10'h000, "ran");
      if (k == 0)
        chk(alarm_indicator === 1'b1, "alarm lamp off");
      wr32(mcu_pkg::RECALC_SETUP_CMD, mcu_pkg::CMD_RESET);
    end
    {alarm_active, motor_running, tool_busy, pc_busy} <= 4'h0;
  endtask

  task t_run();
    wr32(mcu_pkg::RECALC_SETUP_CMD, mcu_pkg::CMD_TRIGGER);
    chk(cmd_fire === 10'h020 && configuring === 1'b1, "no setup");
    alarm_active <= 1'b1;
    wr32(mcu_pkg::RECALC_SETUP_CMD, mcu_pkg::CMD_RESET);
    chk(excitation_off === 1'b1 && brake_hold === 1'b1, "drive");
    chk(inputs_blocked === 1'b1 && outputs_valid === 1'b0, "io");
    chk(alarm_indicator === 1'b0, "lamp lit in setup");
    alarm_active <= 1'b0;
    wr32(mcu_pkg::RECALC_SETUP_CMD, mcu_pkg::CMD_TRIGGER);
    chk(cfg_refused === 1'b1, "retrigger in setup");
    @(posedge mclk);
    recalc_done <= 1'b1;
    @(posedge mclk);
    recalc_done <= 1'b0;
    #1;
    chk(configuring === 1'b0 && zero_positions === 1'b1, "end");
    chk(outputs_valid === 1'b1 && cmd_fire === 10'h000, "out");
    @(posedge mclk);
    #1;
    chk(zero_positions === 1'b0, "zero not a pulse");
    wr32(mcu_pkg::RECALC_SETUP_CMD, mcu_pkg::CMD_RESET);
  endtask

  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    summarize();
  end

  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    {reset_n, req, alarm_active, motor_running} = 4'h0;
    {tool_busy, pc_busy, recalc_done} = 3'h0;
    ce = 1'b1;
    base = 16'h0000;
    value = 32'h0000_0000;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    // the single nv store in t_each keeps storage wear low
    t_each();
    t_reject();
    t_refuse();
    t_run();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
